// [rtl/rtcia_map.svh]
/*
 * Constants of the real-time clock serial access port: bus address,
 * pointer byte fields, reset values and timing counts.
 * Assumes a 200 MHz system clock and a 32.768 kHz timekeeping tick.
 */
`ifndef RTCIA_MAP_SVH
`define RTCIA_MAP_SVH

// target address and pointer byte layout
`define RTCIA_ADDR 7'h32
`define RTCIA_PTR_MSB 7
`define RTCIA_PTR_LSB 4
`define RTCIA_FMT_MSB 3
`define RTCIA_FMT_LSB 0

// reset, format code and fill values
`define RTCIA_PTR_RESET 4'hF
`define RTCIA_FMT_WRITE 4'h0
`define RTCIA_FMT_RD_A 4'h4
`define RTCIA_FMT_RD_B 4'h5
`define RTCIA_FILL 8'hFF

// timing, each time in its own unit and the derived count
`define RTCIA_CLK_MHZ 200
`define RTCIA_TICK_HZ 32768
`define RTCIA_WDOG_MS 500
`define RTCIA_WDOG_TICKS ((`RTCIA_WDOG_MS * `RTCIA_TICK_HZ) / 1000)
`define RTCIA_WDOG_W 15
`define RTCIA_GAP_US 31
`define RTCIA_GAP_CYC (`RTCIA_GAP_US * `RTCIA_CLK_MHZ)
`define RTCIA_GAP_W 13
`define RTCIA_SCL_KHZ 100
`define RTCIA_QTR_CYC ((`RTCIA_CLK_MHZ * 1000) / (`RTCIA_SCL_KHZ * 4))
`define RTCIA_QTR_W 9

`endif

// [rtl/rtcia_pkg.sv]
/*
 * Types shared by both ends of the serial access port.
 * Assumes rtcia_map.svh holds every number.
 */
package rtcia_pkg;

    // commands of the master end
    typedef enum logic [1:0] {
        RTCIA_CMD_START,
        RTCIA_CMD_WRITE,
        RTCIA_CMD_READ,
        RTCIA_CMD_STOP
    } rtcia_cmd_t;

    // target end states
    typedef enum logic [2:0] {
        DS_IDLE,
        DS_RX,
        DS_RX_ACK,
        DS_TX,
        DS_TX_ACK,
        DS_IGNORE
    } rtcia_dst_t;

    // master end states
    typedef enum logic [2:0] {
        HS_IDLE,
        HS_START,
        HS_BIT,
        HS_STOP,
        HS_GAP
    } rtcia_hst_t;

endpackage

// [rtl/rtcia_bus_if.sv]
/*
 * Two-wire bus between master end and target end.
 * Assumes open-drain wires with pull-ups; an enable low pulls the wire down.
 */
`timescale 1ns/100ps

interface rtcia_bus_if;
    logic m_scl_o;
    logic m_scl_oe_n;
    logic m_sda_o;
    logic m_sda_oe_n;
    logic s_sda_o;
    logic s_sda_oe_n;
    logic scl;
    logic sda;

    // wired-and of the open-drain drivers, the pull-up gives the high level
    assign scl = m_scl_oe_n | m_scl_o;
    assign sda = (m_sda_oe_n | m_sda_o) & (s_sda_oe_n | s_sda_o);

    modport dev (input scl, input sda, output s_sda_o, output s_sda_oe_n);
    modport host (input scl, input sda, output m_scl_o, output m_scl_oe_n, output m_sda_o, output m_sda_oe_n);
endinterface

// [rtl/rtcia_line_mon.sv]
/*
 * Bus condition detector: clock edges, start and stop conditions.
 * Assumes scl and sda are synchronous to mclk_i.
 */
`timescale 1ns/100ps

module rtcia_line_mon (
    input wire logic mclk_i, // system clock
    input wire logic reset_i, // synchronous reset
    input wire logic scl_i, // bus clock level
    input wire logic sda_i, // bus data level
    output logic scl_rise_o, // bus clock rose
    output logic scl_fall_o, // bus clock fell
    output logic start_o, // data fell while clock high
    output logic stop_o // data rose while clock high
);
    logic scl_r;
    logic sda_r;
    logic scl_nxt;
    logic sda_nxt;

    ////////////////////////////////////////////////////////////////
    // previous line levels, reset to the idle-high bus
    always_comb begin
        scl_nxt = scl_i;
        sda_nxt = sda_i;
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            scl_r <= 1'b1;
            sda_r <= 1'b1;
        end else begin
            scl_r <= scl_nxt;
            sda_r <= sda_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // conditions need the clock high on both samples so an edge is not misread
    assign scl_rise_o = scl_i & ~scl_r;
    assign scl_fall_o = ~scl_i & scl_r;
    assign start_o = scl_i & scl_r & sda_r & ~sda_i;
    assign stop_o = scl_i & scl_r & ~sda_r & sda_i;
endmodule // rtcia_line_mon

// [rtl/rtcia_dev.sv]
/*
 * Target end of the clock chip serial port: address match, pointer and
 * format byte, auto-increment writes, three read styles, carry hold and
 * a forced release watchdog.
 * Assumes reg_rdata_i is a combinational read of the register at reg_addr_o,
 * and tick_32k_i is a one-cycle pulse at 32.768 kHz from the timekeeper.
 */
// What this block does
// - answer address 0110010, eighth bit gives direction
// - second byte holds pointer and format code
// - master writes use format code 0000 only
// - third byte stored, pointer then auto-increments
// - pointer wraps from Fh to 0h
// - stop loads pointer with Fh
// - pointer read uses format 0, repeated start
// - format 4h or 5h reads straight away
// - bare read starts at current pointer
// - reads increment pointer after each byte
// - hold carries from start, free after stop
// - timeout ends access like a stop
// - timeout counts from first start only
// - after timeout writes nacked, reads give FFh
// - master finishes each access within 0.5 s
// - master waits 31 us after stop
// - master keeps related registers in one access
// - receiver acks ninth clock, last read nacked
`timescale 1ns/100ps
`include "rtcia_map.svh"

module rtcia_dev #(
    parameter int WDOG_TICKS = `RTCIA_WDOG_TICKS // ticks to forced release
) (
    input wire logic mclk_i, // 200 MHz system clock
    input wire logic reset_i, // synchronous reset, high
    rtcia_bus_if.dev bus, // two-wire bus, target side
    input wire logic tick_32k_i, // timekeeping tick pulse
    input wire logic [7:0] reg_rdata_i, // register at reg_addr_o
    output logic [3:0] reg_addr_o, // register address
    output logic [7:0] reg_wdata_o, // write data
    output logic reg_we_o, // write strobe, one cycle
    output logic carry_hold_o, // hold timekeeping carries
    output logic released_o // access forced off by timeout
);
    import rtcia_pkg::*;

    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic wdog_hit;
    logic [7:0] load_byte;

    logic open_r, open_nxt;
    logic rel_r, rel_nxt;
    logic hold_r, hold_nxt;
    logic [`RTCIA_WDOG_W-1:0] wdog_r, wdog_nxt;

    rtcia_dst_t st_r, st_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [1:0] byte_r, byte_nxt;
    logic rd_r, rd_nxt;
    logic rdfmt_r, rdfmt_nxt;
    logic mack_r, mack_nxt;
    logic sda_oe_n_r, sda_oe_n_nxt;
    logic [3:0] ptr_r, ptr_nxt;
    logic [3:0] addr_r, addr_nxt;
    logic [7:0] wdata_r, wdata_nxt;
    logic we_r, we_nxt;

    ////////////////////////////////////////////////////////////////
    // bus conditions
    rtcia_line_mon u_mon (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .scl_i(bus.scl),
        .sda_i(bus.sda),
        .scl_rise_o(scl_rise),
        .scl_fall_o(scl_fall),
        .start_o(start),
        .stop_o(stop)
    );

    ////////////////////////////////////////////////////////////////
    // transaction window, carry hold and watchdog
    assign wdog_hit = open_r & ~rel_r & tick_32k_i & (wdog_r == `RTCIA_WDOG_W'(WDOG_TICKS - 1));

    always_comb begin
        open_nxt = open_r;
        rel_nxt = rel_r;
        wdog_nxt = wdog_r;
        if (stop) begin
            open_nxt = 1'b0;
            rel_nxt = 1'b0;
            wdog_nxt = '0;
        end else if (start && !open_r) begin
            open_nxt = 1'b1;
            wdog_nxt = '0;
        end else if (wdog_hit) begin
            rel_nxt = 1'b1;
            wdog_nxt = '0;
        end else if (open_r && !rel_r && tick_32k_i) begin
            wdog_nxt = wdog_r + 1'b1; // repeated starts leave this alone
        end
        // carries run free again once the window closes or is forced off
        hold_nxt = open_nxt & ~rel_nxt;
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            open_r <= 1'b0;
            rel_r <= 1'b0;
            hold_r <= 1'b0;
            wdog_r <= '0;
        end else begin
            open_r <= open_nxt;
            rel_r <= rel_nxt;
            hold_r <= hold_nxt;
            wdog_r <= wdog_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // byte engine; sda enable follows the bit, since driving low is the only drive
    assign load_byte = rel_r ? `RTCIA_FILL : reg_rdata_i;

    always_comb begin
        st_nxt = st_r;
        shift_nxt = shift_r;
        bit_nxt = bit_r;
        byte_nxt = byte_r;
        rd_nxt = rd_r;
        rdfmt_nxt = rdfmt_r;
        mack_nxt = mack_r;
        sda_oe_n_nxt = sda_oe_n_r;
        ptr_nxt = ptr_r;
        wdata_nxt = wdata_r;
        we_nxt = 1'b0;
        addr_nxt = addr_r;
        if (stop || wdog_hit) begin
            ptr_nxt = `RTCIA_PTR_RESET;
        end
        if (stop) begin
            st_nxt = DS_IDLE;
            sda_oe_n_nxt = 1'b1;
        end else if (start) begin
            // a repeated start keeps the pointer for the read that follows
            st_nxt = DS_RX;
            bit_nxt = 4'h0;
            byte_nxt = 2'h0;
            sda_oe_n_nxt = 1'b1;
        end else begin
            case (st_r)
                DS_RX: begin
                    if (scl_rise) begin
                        shift_nxt = {shift_r[6:0], bus.sda}; // msb first
                        bit_nxt = bit_r + 4'h1;
                    end else if (scl_fall && bit_r == 4'h8) begin
                        st_nxt = DS_IGNORE;
                        if (byte_r == 2'h0) begin
                            if (shift_r[7:1] == `RTCIA_ADDR && (!rel_r || shift_r[0])) begin
                                rd_nxt = shift_r[0]; // high reads
                                st_nxt = DS_RX_ACK;
                                sda_oe_n_nxt = 1'b0;
                            end
                        end else if (!rel_r) begin
                            if (byte_r == 2'h1) begin
                                ptr_nxt = shift_r[`RTCIA_PTR_MSB:`RTCIA_PTR_LSB];
                                // only 4h and 5h turn round, any other code writes
                                rdfmt_nxt = shift_r[`RTCIA_FMT_MSB:`RTCIA_FMT_LSB] == `RTCIA_FMT_RD_A ||
                                    shift_r[`RTCIA_FMT_MSB:`RTCIA_FMT_LSB] == `RTCIA_FMT_RD_B;
                            end
                            st_nxt = DS_RX_ACK;
                            sda_oe_n_nxt = 1'b0;
                        end
                        // released access stays in DS_IGNORE, except a read address byte: no acknowledge
                    end
                end
                DS_RX_ACK: begin
                    if (scl_fall) begin
                        sda_oe_n_nxt = 1'b1;
                        bit_nxt = 4'h0;
                        byte_nxt = (byte_r == 2'h2) ? 2'h2 : byte_r + 2'h1;
                        st_nxt = DS_RX;
                        if (byte_r == 2'h2) begin
                            we_nxt = 1'b1;
                            addr_nxt = ptr_r;
                            wdata_nxt = shift_r;
                            ptr_nxt = ptr_r + 4'h1; // wraps Fh to 0h
                        end else if ((byte_r == 2'h0 && rd_r) || (byte_r == 2'h1 && rdfmt_r)) begin
                            // bare read starts at the pointer left by stop or reset
                            st_nxt = DS_TX;
                            shift_nxt = load_byte;
                            sda_oe_n_nxt = load_byte[7];
                            bit_nxt = 4'h1;
                            ptr_nxt = ptr_r + 4'h1;
                        end
                    end
                end
                DS_TX: begin
                    if (scl_fall) begin
                        if (bit_r == 4'h8) begin
                            sda_oe_n_nxt = 1'b1; // master owns the ninth clock
                            st_nxt = DS_TX_ACK;
                        end else begin
                            shift_nxt = {shift_r[6:0], 1'b1};
                            sda_oe_n_nxt = shift_r[6];
                            bit_nxt = bit_r + 4'h1;
                        end
                    end
                end
                DS_TX_ACK: begin
                    if (scl_rise) begin
                        mack_nxt = ~bus.sda;
                    end else if (scl_fall) begin
                        if (mack_r) begin
                            st_nxt = DS_TX;
                            shift_nxt = load_byte;
                            sda_oe_n_nxt = load_byte[7];
                            bit_nxt = 4'h1;
                            ptr_nxt = ptr_r + 4'h1;
                        end else begin
                            st_nxt = DS_IGNORE; // nack ends the read
                        end
                    end
                end
                DS_IDLE, DS_IGNORE: begin
                end
                default: begin
                    st_nxt = DS_IDLE;
                    sda_oe_n_nxt = 1'b1;
                end
            endcase
        end
        // address follows the pointer so read data is ready before each load
        if (!we_nxt) begin
            addr_nxt = ptr_nxt;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            st_r <= DS_IDLE;
            shift_r <= 8'h00;
            bit_r <= 4'h0;
            byte_r <= 2'h0;
            rd_r <= 1'b0;
            rdfmt_r <= 1'b0;
            mack_r <= 1'b0;
            sda_oe_n_r <= 1'b1;
            ptr_r <= `RTCIA_PTR_RESET;
            addr_r <= `RTCIA_PTR_RESET;
            wdata_r <= 8'h00;
            we_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            shift_r <= shift_nxt;
            bit_r <= bit_nxt;
            byte_r <= byte_nxt;
            rd_r <= rd_nxt;
            rdfmt_r <= rdfmt_nxt;
            mack_r <= mack_nxt;
            sda_oe_n_r <= sda_oe_n_nxt;
            ptr_r <= ptr_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            we_r <= we_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs
    assign bus.s_sda_o = 1'b0;
    assign bus.s_sda_oe_n = sda_oe_n_r;
    assign reg_addr_o = addr_r;
    assign reg_wdata_o = wdata_r;
    assign reg_we_o = we_r;
    assign carry_hold_o = hold_r;
    assign released_o = rel_r;
endmodule // rtcia_dev

// [rtl/rtcia_host.sv]
/*
 * Master end: runs start, byte write, byte read and stop commands on the
 * two-wire bus, one quarter bit period per phase, with a quiet gap after stop.
 * Assumes the user sequences bytes into whole accesses; no clock stretching.
 */
`timescale 1ns/100ps
`include "rtcia_map.svh"

module rtcia_host #(
    parameter int GAP_CYC = `RTCIA_GAP_CYC, // cycles of quiet after stop
    parameter int QTR_CYC = `RTCIA_QTR_CYC // quarter bit cycles
) (
    input wire logic mclk_i, // 200 MHz system clock
    input wire logic reset_i, // synchronous reset, high
    rtcia_bus_if.host bus, // two-wire bus, master side
    input wire logic cmd_valid_i, // command offered
    input wire rtcia_pkg::rtcia_cmd_t cmd_i, // command code
    input wire logic [7:0] wdata_i, // byte to write
    input wire logic last_i, // read: nack this byte
    output logic cmd_ready_o, // command taken when valid
    output logic done_o, // command finished, one cycle
    output logic [7:0] rdata_o, // byte read
    output logic ack_o // write acknowledged by target
);
    import rtcia_pkg::*;

    logic qtick;
    rtcia_hst_t st_r, st_nxt;
    logic [`RTCIA_QTR_W-1:0] q_r, q_nxt;
    logic [1:0] ph_r, ph_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [8:0] tx_r, tx_nxt;
    logic [7:0] rx_r, rx_nxt;
    logic [`RTCIA_GAP_W-1:0] gap_r, gap_nxt;
    logic scl_oe_n_r, scl_oe_n_nxt;
    logic sda_oe_n_r, sda_oe_n_nxt;
    logic ready_r, ready_nxt;
    logic done_r, done_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic ack_r, ack_nxt;

    assign qtick = q_r == `RTCIA_QTR_W'(QTR_CYC - 1);

    ////////////////////////////////////////////////////////////////
    // command sequencer, four phases per bit or condition
    always_comb begin
        st_nxt = st_r;
        q_nxt = (st_r == HS_IDLE || st_r == HS_GAP || qtick) ? '0 : q_r + 1'b1;
        ph_nxt = ph_r;
        bit_nxt = bit_r;
        tx_nxt = tx_r;
        rx_nxt = rx_r;
        gap_nxt = gap_r;
        scl_oe_n_nxt = scl_oe_n_r;
        sda_oe_n_nxt = sda_oe_n_r;
        ready_nxt = ready_r;
        done_nxt = 1'b0;
        rdata_nxt = rdata_r;
        ack_nxt = ack_r;
        case (st_r)
            HS_IDLE: begin
                if (cmd_valid_i) begin
                    ready_nxt = 1'b0;
                    ph_nxt = 2'h0;
                    bit_nxt = 4'h0;
                    case (cmd_i)
                        RTCIA_CMD_START: st_nxt = HS_START;
                        RTCIA_CMD_STOP: st_nxt = HS_STOP;
                        RTCIA_CMD_WRITE: begin
                            // pointer byte carries format 0h for writes and pointed reads
                            tx_nxt = {wdata_i, 1'b1};
                            st_nxt = HS_BIT;
                        end
                        default: begin
                            tx_nxt = {8'hFF, last_i}; // no ack on the last byte read
                            st_nxt = HS_BIT;
                        end
                    endcase
                end
            end
            HS_START: begin
                // works from idle and as a repeated start with the clock low
                if (qtick) begin
                    ph_nxt = ph_r + 2'h1;
                    case (ph_r)
                        2'h0: sda_oe_n_nxt = 1'b1;
                        2'h1: scl_oe_n_nxt = 1'b1;
                        2'h2: sda_oe_n_nxt = 1'b0;
                        default: begin
                            scl_oe_n_nxt = 1'b0;
                            st_nxt = HS_IDLE;
                            ready_nxt = 1'b1;
                            done_nxt = 1'b1;
                        end
                    endcase
                end
            end
            HS_BIT: begin
                if (qtick) begin
                    ph_nxt = ph_r + 2'h1;
                    case (ph_r)
                        2'h0: sda_oe_n_nxt = tx_r[8];
                        2'h1: scl_oe_n_nxt = 1'b1;
                        2'h2: begin
                            if (bit_r == 4'h8) begin
                                ack_nxt = ~bus.sda;
                            end else begin
                                rx_nxt = {rx_r[6:0], bus.sda};
                            end
                        end
                        default: begin
                            scl_oe_n_nxt = 1'b0;
                            tx_nxt = {tx_r[7:0], 1'b1};
                            bit_nxt = bit_r + 4'h1;
                            if (bit_r == 4'h8) begin
                                sda_oe_n_nxt = 1'b1;
                                rdata_nxt = rx_r;
                                st_nxt = HS_IDLE;
                                ready_nxt = 1'b1;
                                done_nxt = 1'b1;
                            end
                        end
                    endcase
                end
            end
            HS_STOP: begin
                if (qtick) begin
                    ph_nxt = ph_r + 2'h1;
                    case (ph_r)
                        2'h0: sda_oe_n_nxt = 1'b0;
                        2'h1: scl_oe_n_nxt = 1'b1;
                        2'h2: sda_oe_n_nxt = 1'b1;
                        default: begin
                            st_nxt = HS_GAP;
                            gap_nxt = '0;
                            done_nxt = 1'b1;
                        end
                    endcase
                end
            end
            HS_GAP: begin
                // the target applies a held carry in this quiet time
                if (gap_r == `RTCIA_GAP_W'(GAP_CYC - 1)) begin
                    st_nxt = HS_IDLE;
                    ready_nxt = 1'b1;
                end else begin
                    gap_nxt = gap_r + 1'b1;
                end
            end
            default: begin
                st_nxt = HS_IDLE;
                ready_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            st_r <= HS_IDLE;
            q_r <= '0;
            ph_r <= 2'h0;
            bit_r <= 4'h0;
            tx_r <= 9'h1FF;
            rx_r <= 8'h00;
            gap_r <= '0;
            scl_oe_n_r <= 1'b1;
            sda_oe_n_r <= 1'b1;
            ready_r <= 1'b1;
            done_r <= 1'b0;
            rdata_r <= 8'h00;
            ack_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            q_r <= q_nxt;
            ph_r <= ph_nxt;
            bit_r <= bit_nxt;
            tx_r <= tx_nxt;
            rx_r <= rx_nxt;
            gap_r <= gap_nxt;
            scl_oe_n_r <= scl_oe_n_nxt;
            sda_oe_n_r <= sda_oe_n_nxt;
            ready_r <= ready_nxt;
            done_r <= done_nxt;
            rdata_r <= rdata_nxt;
            ack_r <= ack_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs
    assign bus.m_scl_o = 1'b0;
    assign bus.m_sda_o = 1'b0;
    assign bus.m_scl_oe_n = scl_oe_n_r;
    assign bus.m_sda_oe_n = sda_oe_n_r;
    assign cmd_ready_o = ready_r;
    assign done_o = done_r;
    assign rdata_o = rdata_r;
    assign ack_o = ack_r;
endmodule // rtcia_host

// [verif/rtcia_chk.sv]
/* checker on the two-wire bus joining both ends.
   assumes wires sampled on mclk_i, reset_i synchronous high. */
`timescale 1ns/100ps
module rtcia_chk (
    input wire logic mclk_i, // system clock
    input wire logic reset_i, // synchronous reset
    input wire logic m_scl_oe_n, // master clock pull
    input wire logic m_sda_oe_n, // master data pull
    input wire logic s_sda_oe_n, // target data pull
    input wire logic scl, // clock wire
    input wire logic sda // data wire
);
    ////////////////////////////////////////
    // one domain, so clock and reset stand once
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    bus_free_a: assert property ($fell(reset_i) |-> s_sda_oe_n && m_sda_oe_n && m_scl_oe_n)
        else $error("bus not released after reset");
    // the target moves data only while the clock is low
    ack_take_a: assert property ($fell(s_sda_oe_n) |-> !scl)
        else $error("target pulled data with clock high");
    ack_free_a: assert property ($rose(s_sda_oe_n) |-> !scl)
        else $error("target released data with clock high");
    ack_hold_a: assert property ($fell(s_sda_oe_n) |-> !sda [*8])
        else $error("target data pull too short");
    clk_high_a: assert property ($rose(scl) |-> scl [*8])
        else $error("clock high phase too short");
    clk_low_a: assert property ($fell(scl) |-> !scl [*8])
        else $error("clock low phase too short");
    stop_gap_a: assert property (scl && $rose(sda) |-> sda [*8])
        else $error("start too soon after stop");
    start_keep_a: assert property (scl && $fell(sda) |-> scl [*8])
        else $error("clock fell right after start");
    cover property ($fell(s_sda_oe_n));
    cover property (scl && $fell(sda));
    cover property (scl && $rose(sda));
endmodule // rtcia_chk

// [verif/tb_rtc_i2c_access_port.sv]
/* bench: master end and target end joined, register file model.
   assumes short gap and watchdog parameters. */
`timescale 1ns/100ps
module tb_rtc_i2c_access_port;
    import rtcia_pkg::*;
    logic mclk_i = 0, reset_i = 1, cmd_valid_i = 0, last_i = 0, tick_32k_i = 0;
    rtcia_cmd_t cmd_i = RTCIA_CMD_START;
    logic [7:0] wdata_i = 8'h00, rdata_o, reg_wdata_o, reg_rdata_i;
    logic [7:0] rf [16];
    logic [3:0] reg_addr_o;
    logic cmd_ready_o, done_o, ack_o, reg_we_o, carry_hold_o, released_o;
    int miscompares = 0, checks = 0;
    rtcia_bus_if bus ();
    rtcia_host #(.GAP_CYC(20), .QTR_CYC(20)) u_rtcia_host (.mclk_i, .reset_i, .bus(bus.host), .cmd_valid_i, .cmd_i,
        .wdata_i, .last_i, .cmd_ready_o, .done_o, .rdata_o, .ack_o);
    rtcia_dev #(.WDOG_TICKS(8)) u_rtcia_dev (.mclk_i, .reset_i, .bus(bus.dev), .tick_32k_i, .reg_rdata_i,
        .reg_addr_o, .reg_wdata_o, .reg_we_o, .carry_hold_o, .released_o);
    rtcia_chk u_rtcia_chk (.mclk_i, .reset_i, .m_scl_oe_n(bus.m_scl_oe_n), .m_sda_oe_n(bus.m_sda_oe_n),
        .s_sda_oe_n(bus.s_sda_oe_n), .scl(bus.scl), .sda(bus.sda));
    ////////////////////////////////////////
    // clock, and a register file read without delay
    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end
    assign reg_rdata_i = rf[reg_addr_o];
    always @(posedge mclk_i) if (reg_we_o) rf[reg_addr_o] <= reg_wdata_o;
    ////////////////////////////////////////
    task automatic ck(input string nm, input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic results;
        if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // one command: hold valid until taken, then wait for done, both bounded
    task automatic cmd(input rtcia_cmd_t c, input logic [7:0] d = 8'h00, input logic l = 0);
        int n;
        @(negedge mclk_i);
        cmd_valid_i = 1;
        cmd_i = c;
        wdata_i = d;
        last_i = l;
        for (n = 0; cmd_ready_o !== 1'b1 && n < 99; n++) @(negedge mclk_i);
        if (n >= 99) miscompares++;
        @(negedge mclk_i);
        cmd_valid_i = 0;
        for (n = 0; done_o !== 1'b1 && n < 40000; n++) @(negedge mclk_i);
        if (n >= 40000) begin
            miscompares++;
            results;
        end
    endtask
    task automatic ticks(input int k);
        repeat (k) begin
            @(negedge mclk_i) tick_32k_i = 1;
            @(negedge mclk_i) tick_32k_i = 0;
        end
        repeat (3) @(negedge mclk_i);
    endtask
    ////////////////////////////////////////
    // one access writes Eh over the top of the map
    task automatic sc_write;
        cmd(RTCIA_CMD_START);
        ck("hold", carry_hold_o, 8'h01);
        cmd(RTCIA_CMD_WRITE, 8'h64);
        ck("ack", ack_o, 8'h01);
        cmd(RTCIA_CMD_WRITE, 8'hE0);
        cmd(RTCIA_CMD_WRITE, 8'hA5);
        cmd(RTCIA_CMD_WRITE, 8'h5A);
        cmd(RTCIA_CMD_WRITE, 8'h3C);
        cmd(RTCIA_CMD_STOP);
        repeat (3) @(negedge mclk_i);
        ck("hold", carry_hold_o, 8'h00);
        ck("re", rf[14], 8'hA5);
        ck("rf", rf[15], 8'h5A);
        ck("r0", rf[0], 8'h3C);
    endtask
    // format 4 or 5 read straight after the pointer byte
    task automatic sc_rd4(input logic [7:0] pf);
        cmd(RTCIA_CMD_START);
        cmd(RTCIA_CMD_WRITE, 8'h64);
        cmd(RTCIA_CMD_WRITE, pf);
        cmd(RTCIA_CMD_READ);
        ck("rd", rdata_o, 8'hA5);
        cmd(RTCIA_CMD_READ, 8'h00, 1);
        ck("rd", rdata_o, 8'h5A);
        cmd(RTCIA_CMD_STOP);
    endtask
    // bare read from Fh, then pointer set and repeated start read
    task automatic sc_rs;
        cmd(RTCIA_CMD_START);
        cmd(RTCIA_CMD_WRITE, 8'h65);
        cmd(RTCIA_CMD_READ, 8'h00, 1);
        ck("bare", rdata_o, 8'h5A);
        cmd(RTCIA_CMD_START);
        cmd(RTCIA_CMD_WRITE, 8'h64);
        cmd(RTCIA_CMD_WRITE, 8'h20);
        cmd(RTCIA_CMD_START);
        cmd(RTCIA_CMD_WRITE, 8'h65);
        cmd(RTCIA_CMD_READ, 8'h00, 1);
        ck("rs", rdata_o, 8'hC2);
        cmd(RTCIA_CMD_START);
        cmd(RTCIA_CMD_WRITE, 8'h66);
        ck("nack", ack_o, 8'h00);
        cmd(RTCIA_CMD_STOP);
    endtask
    // watchdog spans a repeated start, then a write is nacked and a read gives FFh
    task automatic sc_wdog;
        cmd(RTCIA_CMD_START);
        ticks(4);
        cmd(RTCIA_CMD_START);
        ticks(3);
        ck("rel", released_o, 8'h00);
        ticks(1);
        ck("rel", released_o, 8'h01);
        ck("hold", carry_hold_o, 8'h00);
        cmd(RTCIA_CMD_WRITE, 8'h64);
        ck("ack", ack_o, 8'h00);
        cmd(RTCIA_CMD_START);
        cmd(RTCIA_CMD_WRITE, 8'h65);
        cmd(RTCIA_CMD_READ, 8'h00, 1);
        ck("fill", rdata_o, 8'hFF);
        cmd(RTCIA_CMD_STOP);
        ck("rel", released_o, 8'h00);
    endtask
    ////////////////////////////////////////
    initial begin
        foreach (rf[i]) rf[i] = 8'hC0 | 8'(i);
        repeat (16) @(negedge mclk_i);
        reset_i = 0;
        ck("ptr", reg_addr_o, 8'h0F);
        sc_write;
        sc_rd4(8'hE4);
        sc_rd4(8'hE5);
        sc_rs;
        sc_wdog;
        results;
    end
endmodule // tb_rtc_i2c_access_port
